// ### inc/eic_pkg.sv
// package: constants and types for the exception and interrupt control unit
package eic_pkg;

    // ****************************************
    // control register indices
    // ****************************************
    localparam logic [2:0] CTL_STATE     = 3'h0;
    localparam logic [2:0] CTL_EXC_SAVED = 3'h1;
    localparam logic [2:0] CTL_BRK_SAVED = 3'h2;
    localparam logic [2:0] CTL_IRQ_MASK  = 3'h3;
    localparam logic [2:0] CTL_IRQ_ACT   = 3'h4;
    localparam logic [2:0] CTL_CPU_ID    = 3'h5;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int          IRQ_LINES        = 32;
    localparam int          GIE_POS          = 0;
    localparam logic [31:0] STATE_RESET      = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
    localparam logic [31:0] SAVED_RESET      = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET       = 32'h0000_0000;
    localparam logic [31:0] INSN_BYTES       = 32'h0000_0004;
    localparam int          SYNC_STAGES      = 2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,
        MODE_DEBUG  = 2'b10
    } eic_mode_t;

    // one retiring instruction as seen by this unit
    typedef struct packed {
        logic        valid;      // instruction boundary reached
        logic [31:0] pc;         // address of retiring instruction
        logic        is_trap;
        logic        is_unimpl;
        logic        is_eret;
        logic        is_break;
        logic        is_bret;
        logic        ctl_wr;
        logic [2:0]  ctl_idx;
        logic [31:0] ctl_wdata;
    } eic_retire_t;

    // fetch redirect produced by this unit
    typedef struct packed {
        logic        valid;
        logic [31:0] target;
    } eic_redirect_t;

endpackage : eic_pkg

// ### hw/eic_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module eic_sync #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_b_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : eic_sync

// ### hw/eic_top.sv
// exception, interrupt and debug-mode control unit
//
// How it works
// RULE_01: global enable clear means request lines are ignored, no interrupt taken.
// RULE_02: interrupt taken when enable set and some line asserted with its mask bit.
// RULE_03: mask bit n enables request line n when one, disables when zero.
// RULE_04: active bit n is line n and mask n; writes have no effect.
// RULE_05: identifier register returns a fixed constant; writes ignored.
// RULE_06: exception entry saves state register then clears global enable.
// RULE_07: exception entry loads return address with next instruction, redirects to handler.
// RULE_08: handler address is a fixed parameter, not software writable.
// RULE_09: exception return copies saved state back into state register.
// RULE_10: debug break copies state register into break saved state.
// RULE_11: reset leaves the unit in normal mode.
// RULE_12: debug mode entered only by break instruction or forced hardware break.
// RULE_13: leaving debug mode restores state held before the break.
// RULE_14: trap instruction takes a software trap through common entry.
// RULE_15: unimplemented instruction takes an exception, never undefined behaviour.
// RULE_16: peripherals hold requests asserted until serviced.
// RULE_17: break temp, break return and break saved state belong to debug mode.
// RULE_18: handler classifies interrupt via saved enable and nonzero active register.
// RULE_19: service routine hides its request before returning or re-enabling.
// RULE_20: routine saves exception state and return address before nesting.
// RULE_21: writing one to global enable re-enables interrupts, allowing nesting.
// RULE_22: reset clears whole state register to zero.
// RULE_23: exception return redirects to the exception return address.
// RULE_24: break writes next-instruction address into break return address.
// RULE_25: break return restores state from break copy, resumes at break return address.
// RULE_26: interrupts recognised only at instruction boundaries.
// RULE_27: active register is synchronised requests anded with mask each cycle.
`timescale 1ns/1ps
module eic_top
    import eic_pkg::*;
#(
    parameter logic [31:0] EXC_HANDLER_ADDR = 32'h0000_0020,  // fixed at generation
    parameter logic [31:0] BRK_HANDLER_ADDR = 32'h0000_0040,  // fixed at generation
    parameter logic [31:0] CPU_ID_VALUE     = 32'h0000_00a5   // arbitrary value
) (
    // clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    // peripheral requests, asynchronous levels
    input  wire logic [IRQ_LINES-1:0] interrupt_request_lines_i,
    // debug module forced break, asynchronous level
    input  wire logic                 debug_break_req_i,
    // retiring instruction from the pipeline
    input  wire eic_retire_t          retire_i,
    // control register read port
    input  wire logic [2:0]           ctl_rd_idx_i,
    output logic      [31:0]          ctl_rdata_o,
    // fetch redirect and taken-exception view
    output eic_redirect_t             redirect_o,
    output logic                      irq_taken_o,
    output logic                      debug_mode_o,
    output logic      [31:0]          exception_return_addr_reg_o,
    output logic      [31:0]          break_return_addr_reg_o
);

    // ****************************************
    // state
    // ****************************************
    logic [31:0]          state_q;
    logic [31:0]          exc_saved_q;
    logic [31:0]          brk_saved_q;
    logic [31:0]          mask_q;
    logic [31:0]          ea_q;
    logic [31:0]          ba_q;
    eic_mode_t            mode_q;
    logic [IRQ_LINES-1:0] irq_sync;
    logic                 brk_sync;
    logic                 brk_seen_q;
    logic                 brk_pend_q;
    logic [31:0]          active;
    logic                 irq_fire;
    logic                 exc_take;
    logic                 brk_take;
    logic                 hw_brk;
    logic [31:0]          next_pc;
    logic                 wr_ok;

    // ****************************************
    // request synchronisers
    // ****************************************
    eic_sync #(.WIDTH(IRQ_LINES)) u_irq_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .async_i (interrupt_request_lines_i),
        .sync_o  (irq_sync)
    );

    eic_sync #(.WIDTH(1)) u_brk_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .async_i (debug_break_req_i),
        .sync_o  (brk_sync)
    );

    // ****************************************
    // event decode
    // ****************************************
    assign active   = irq_sync & mask_q;                                   // [RULE_03] [RULE_27]
    // requests only count at a retiring boundary and outside debug mode
    assign irq_fire = retire_i.valid && state_q[GIE_POS] && (|active)      // [RULE_01] [RULE_02]
                      && (mode_q == MODE_NORMAL);                           // [RULE_26]
    // forced break edge, so a held request breaks once; the edge is kept
    // pending until a boundary takes it, else a rise between retires is lost
    assign hw_brk   = (brk_pend_q || (brk_sync && !brk_seen_q)) && (mode_q == MODE_NORMAL);
    assign brk_take = retire_i.valid && (mode_q == MODE_NORMAL)
                      && (retire_i.is_break || hw_brk);                     // [RULE_12]
    // break has priority over every exception
    assign exc_take = !brk_take && retire_i.valid
                      && (irq_fire || retire_i.is_trap                      // [RULE_14]
                          || retire_i.is_unimpl);                           // [RULE_15]
    assign next_pc  = retire_i.pc + INSN_BYTES;
    assign wr_ok    = retire_i.valid && retire_i.ctl_wr && !brk_take && !exc_take;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_seen_q <= 1'b0;
        end else begin
            brk_seen_q <= brk_sync;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_pend_q <= 1'b0;
        end else begin
            brk_pend_q <= hw_brk && !brk_take;                              // [RULE_12]
        end
    end

    // ****************************************
    // operating mode
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q <= MODE_NORMAL;                                          // [RULE_11]
        end else if (brk_take) begin
            mode_q <= MODE_DEBUG;                                           // [RULE_12]
        end else if (retire_i.valid && retire_i.is_bret && mode_q == MODE_DEBUG) begin
            mode_q <= MODE_NORMAL;                                          // [RULE_13]
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= STATE_RESET;                                         // [RULE_22]
        end else if (brk_take || exc_take) begin
            state_q[GIE_POS] <= 1'b0;                                       // [RULE_06]
        end else if (retire_i.valid && retire_i.is_eret) begin
            state_q <= exc_saved_q;                                         // [RULE_09]
        end else if (retire_i.valid && retire_i.is_bret && mode_q == MODE_DEBUG) begin
            state_q <= brk_saved_q;                                         // [RULE_25] [RULE_13]
        end else if (wr_ok && retire_i.ctl_idx == CTL_STATE) begin
            // only the enable bit is defined, the rest read zero
            state_q <= {31'h0000_0000, retire_i.ctl_wdata[GIE_POS]};         // [RULE_21]
        end
    end

    // ****************************************
    // saved copies
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            exc_saved_q <= SAVED_RESET;
        end else if (exc_take) begin
            exc_saved_q <= state_q;                                         // [RULE_06]
        end else if (wr_ok && retire_i.ctl_idx == CTL_EXC_SAVED) begin
            exc_saved_q <= {31'h0000_0000, retire_i.ctl_wdata[GIE_POS]};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_saved_q <= SAVED_RESET;
        end else if (brk_take) begin
            brk_saved_q <= state_q;                                         // [RULE_10] [RULE_17]
        end else if (wr_ok && retire_i.ctl_idx == CTL_BRK_SAVED) begin
            brk_saved_q <= {31'h0000_0000, retire_i.ctl_wdata[GIE_POS]};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= MASK_RESET;
        end else if (wr_ok && retire_i.ctl_idx == CTL_IRQ_MASK) begin
            mask_q <= retire_i.ctl_wdata;                                   // [RULE_03]
        end
    end
    // writes to the active and identifier indices fall through unstored [RULE_04] [RULE_05]

    // ****************************************
    // return addresses
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ea_q <= ADDR_RESET;
        end else if (exc_take) begin
            ea_q <= next_pc;                                                // [RULE_07]
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ba_q <= ADDR_RESET;
        end else if (brk_take) begin
            ba_q <= next_pc;                                                // [RULE_24] [RULE_17]
        end
    end

    // ****************************************
    // redirect
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            redirect_o  <= '0;
            irq_taken_o <= 1'b0;
        end else begin
            irq_taken_o <= exc_take && irq_fire;
            if (brk_take) begin
                redirect_o <= '{valid: 1'b1, target: BRK_HANDLER_ADDR};
            end else if (exc_take) begin
                redirect_o <= '{valid: 1'b1, target: EXC_HANDLER_ADDR};     // [RULE_07] [RULE_08]
            end else if (retire_i.valid && retire_i.is_eret) begin
                redirect_o <= '{valid: 1'b1, target: ea_q};                 // [RULE_23]
            end else if (retire_i.valid && retire_i.is_bret && mode_q == MODE_DEBUG) begin
                redirect_o <= '{valid: 1'b1, target: ba_q};                 // [RULE_25]
            end else begin
                redirect_o <= '0;
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_rdata_o <= 32'h0000_0000;
        end else begin
            unique case (ctl_rd_idx_i)
                CTL_STATE:     ctl_rdata_o <= state_q;
                CTL_EXC_SAVED: ctl_rdata_o <= exc_saved_q;
                CTL_BRK_SAVED: ctl_rdata_o <= brk_saved_q;
                CTL_IRQ_MASK:  ctl_rdata_o <= mask_q;
                CTL_IRQ_ACT:   ctl_rdata_o <= active;                       // [RULE_04]
                CTL_CPU_ID:    ctl_rdata_o <= CPU_ID_VALUE;                 // [RULE_05]
                default:       ctl_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    assign debug_mode_o                = (mode_q == MODE_DEBUG);
    assign exception_return_addr_reg_o = ea_q;
    assign break_return_addr_reg_o     = ba_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_exc_entry;
        exc_take ##1 (redirect_o.valid && redirect_o.target == EXC_HANDLER_ADDR);
    endsequence

    a_gie_blocks_irq: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_01]
        !state_q[GIE_POS] |=> !irq_taken_o) else $error("irq taken while disabled");

    a_irq_fires_exact: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_02]
        (retire_i.valid && !brk_take && mode_q == MODE_NORMAL && state_q[GIE_POS]
         && |(irq_sync & mask_q)) |=> irq_taken_o) else $error("irq not taken");

    a_active_view: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_04]
        ##1 (ctl_rd_idx_i == CTL_IRQ_ACT) |=> ctl_rdata_o == $past(irq_sync & mask_q))
        else $error("active register mismatch");

    a_cpuid_const: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_05]
        ##1 (ctl_rd_idx_i == CTL_CPU_ID) |=> ctl_rdata_o == CPU_ID_VALUE)
        else $error("identifier changed");

    a_exc_save_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_06]
        exc_take |=> (exc_saved_q == $past(state_q)) && !state_q[GIE_POS])
        else $error("exception entry state wrong");

    a_exc_redirect: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_07]
        exc_take |-> s_exc_entry) else $error("no handler redirect");

    a_ea_load: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_07]
        exc_take |=> ea_q == $past(retire_i.pc) + INSN_BYTES) else $error("ea wrong");

    a_eret_restore: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_09]
        (retire_i.valid && retire_i.is_eret && !brk_take && !exc_take)
        |=> state_q == $past(exc_saved_q) && redirect_o.target == $past(ea_q))
        else $error("eret restore wrong");

    a_break_save: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_10]
        brk_take |=> brk_saved_q == $past(state_q) && debug_mode_o
                     && ba_q == $past(retire_i.pc) + INSN_BYTES)
        else $error("break entry wrong");

    a_debug_only_break: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_12]
        $rose(debug_mode_o) |-> $past(brk_take)) else $error("debug entered without break");

    a_bret_resume: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE_13]
        (retire_i.valid && retire_i.is_bret && debug_mode_o)
        |=> !debug_mode_o && state_q == $past(brk_saved_q)) else $error("bret resume wrong");

endmodule : eic_top

// ### testbench/eic_periph_model.sv
// far-side model: peripherals holding level requests and a debug break line
`timescale 1ns/1ps
module eic_periph_model (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // bench commands
    input  wire logic [31:0] raise_i,
    input  wire logic [31:0] service_i,
    input  wire logic        force_brk_i,
    // lines towards the unit
    output logic      [31:0] irq_lines_o,
    output logic             brk_line_o
);
    // ****************************************
    // request lines
    // ****************************************
    // a request stays up until the processor services its source
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_lines_o <= 32'h0000_0000;
        end else begin
            irq_lines_o <= (irq_lines_o | raise_i) & ~service_i;
        end
    end

    // ****************************************
    // debug module break
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_line_o <= 1'b0;
        end else begin
            brk_line_o <= force_brk_i;
        end
    end
endmodule : eic_periph_model

// ### testbench/eic_top_test.sv
// self-checking bench for the exception and interrupt control unit
`timescale 1ns/1ps
module eic_top_test;
    import eic_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic          mclk_i    = 1'b0;
    logic          rst_b_i   = 1'b0;
    logic [31:0]   raise_q   = 32'h0;
    logic [31:0]   service_q = 32'h0;
    logic          brk_q     = 1'b0;
    eic_retire_t   retire_q  = '0;
    logic [2:0]    rd_idx_q  = 3'h0;
    logic [31:0]   irq_lines, ctl_rdata, ea, ba;
    logic          brk_line, irq_taken, debug_mode;
    eic_redirect_t redirect;
    int            errors    = 0;
    int            tests_run = 0;
    localparam logic [4:0] K_TRAP = 5'h10, K_UNIMPL = 5'h08, K_ERET = 5'h04;
    localparam logic [4:0] K_BRK = 5'h02, K_BRET = 5'h01;

    always #2.5 mclk_i = ~mclk_i;

    eic_periph_model eic_periph_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .raise_i(raise_q), .service_i(service_q), .force_brk_i(brk_q),
        .irq_lines_o(irq_lines), .brk_line_o(brk_line));

    eic_top eic_top_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .interrupt_request_lines_i(irq_lines), .debug_break_req_i(brk_line),
        .retire_i(retire_q), .ctl_rd_idx_i(rd_idx_q), .ctl_rdata_o(ctl_rdata),
        .redirect_o(redirect), .irq_taken_o(irq_taken), .debug_mode_o(debug_mode),
        .exception_return_addr_reg_o(ea), .break_return_addr_reg_o(ba));

    // ****************************************
    // tasks
    // ****************************************
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function eic_retire_t mk(input logic [31:0] pc, input logic [4:0] k);
        mk       = '0;
        mk.valid = 1'b1;
        mk.pc    = pc;
        {mk.is_trap, mk.is_unimpl, mk.is_eret, mk.is_break, mk.is_bret} = k;
    endfunction : mk

    // one retire, redirect and taken flag looked at in their single cycle
    task ret(input eic_retire_t r, input logic ev, input logic [31:0] et, input logic ei);
        @(posedge mclk_i);
        retire_q <= r;
        @(posedge mclk_i);
        retire_q <= '0;
        #1;
        chk("redirect_valid", {31'h0, ev}, {31'h0, redirect.valid});
        if (ev) chk("redirect_target", et, redirect.target);
        chk("irq_taken", {31'h0, ei}, {31'h0, irq_taken});
    endtask : ret

    task wr(input logic [2:0] idx, input logic [31:0] d);
        eic_retire_t r;
        r           = mk(32'h0000_0080, 5'h00);
        r.ctl_wr    = 1'b1;
        r.ctl_idx   = idx;
        r.ctl_wdata = d;
        ret(r, 1'b0, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [2:0] idx, input logic [31:0] exp, input string what);
        @(posedge mclk_i);
        rd_idx_q <= idx;
        @(posedge mclk_i);
        #1;
        chk(what, exp, ctl_rdata);
    endtask : rd

    // lines change, then two synchroniser edges plus margin
    task lines(input logic [31:0] up, input logic [31:0] down);
        @(posedge mclk_i);
        raise_q   <= up;
        service_q <= down;
        @(posedge mclk_i);
        raise_q   <= 32'h0;
        service_q <= 32'h0;
        repeat (4) @(posedge mclk_i);
    endtask : lines

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(CTL_STATE, STATE_RESET, "state");
        rd(CTL_IRQ_MASK, MASK_RESET, "mask");
        chk("debug_mode", 32'h0, {31'h0, debug_mode});
        wr(CTL_CPU_ID, 32'hffff_ffff);
        rd(CTL_CPU_ID, 32'h0000_00a5, "cpu_id");
        wr(CTL_IRQ_ACT, 32'hffff_ffff);
        rd(CTL_IRQ_ACT, 32'h0, "active_wr");
        $display("test reset_and_fixed done");
        wr(CTL_IRQ_MASK, 32'h0000_0004);
        lines(32'h0000_000c, 32'h0);
        rd(CTL_IRQ_ACT, 32'h0000_0004, "active");
        ret(mk(32'h0000_0100, 5'h00), 1'b0, 32'h0, 1'b0);
        wr(CTL_STATE, 32'h1);
        ret(mk(32'h0000_0100, 5'h00), 1'b1, 32'h0000_0020, 1'b1);
        chk("ea", 32'h0000_0104, ea);
        rd(CTL_EXC_SAVED, 32'h1, "exc_saved");
        rd(CTL_STATE, 32'h0, "state_cleared");
        ret(mk(32'h0000_0104, 5'h00), 1'b0, 32'h0, 1'b0);
        $display("test interrupt_entry done");
        // service hides line 2 before interrupts come back on
        lines(32'h0, 32'h0000_0004);
        rd(CTL_EXC_SAVED, 32'h1, "exc_saved_nest");
        chk("ea_nest", 32'h0000_0104, ea);
        wr(CTL_STATE, 32'h1);
        wr(CTL_IRQ_MASK, 32'h0000_0008);
        ret(mk(32'h0000_0200, 5'h00), 1'b1, 32'h0000_0020, 1'b1);
        wr(CTL_IRQ_MASK, 32'h0);
        ret(mk(32'h0000_0300, K_ERET), 1'b1, 32'h0000_0204, 1'b0);
        rd(CTL_STATE, 32'h1, "state_eret");
        $display("test nested_and_return done");
        ret(mk(32'h0000_0400, K_TRAP), 1'b1, 32'h0000_0020, 1'b0);
        chk("ea_trap", 32'h0000_0404, ea);
        rd(CTL_EXC_SAVED, 32'h1, "exc_saved_trap");
        ret(mk(32'h0000_0500, K_UNIMPL), 1'b1, 32'h0000_0020, 1'b0);
        chk("ea_unimpl", 32'h0000_0504, ea);
        rd(CTL_EXC_SAVED, 32'h0, "exc_saved_unimpl");
        $display("test trap_unimpl done");
        ret(mk(32'h0000_0510, K_BRET), 1'b0, 32'h0, 1'b0);
        wr(CTL_STATE, 32'h1);
        ret(mk(32'h0000_0600, K_BRK), 1'b1, 32'h0000_0040, 1'b0);
        chk("debug_on", 32'h1, {31'h0, debug_mode});
        chk("ba", 32'h0000_0604, ba);
        rd(CTL_BRK_SAVED, 32'h1, "brk_saved");
        ret(mk(32'h0000_0700, K_BRET), 1'b1, 32'h0000_0604, 1'b0);
        chk("debug_off", 32'h0, {31'h0, debug_mode});
        rd(CTL_STATE, 32'h1, "state_bret");
        @(posedge mclk_i);
        brk_q <= 1'b1;
        repeat (4) @(posedge mclk_i);
        ret(mk(32'h0000_0800, 5'h00), 1'b1, 32'h0000_0040, 1'b0);
        chk("ba_forced", 32'h0000_0804, ba);
        @(posedge mclk_i);
        brk_q <= 1'b0;
        ret(mk(32'h0000_0900, K_BRET), 1'b1, 32'h0000_0804, 1'b0);
        rd(CTL_STATE, 32'h1, "state_forced");
        $display("test debug_mode done");
        report_and_stop();
    end
endmodule : eic_top_test
